// ===== inc/dac_pkg.sv
// Constants, register layout and carriers for the DMA channel arbiter.
// Assumes a single ref_clk domain and a plain address/strobe register port.
package dac_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned NSUB = 4;
   localparam logic [3:0] OFS_CTRL_LOW = 4'h0;
   localparam logic [3:0] OFS_CTRL_HIGH = 4'h1;
   localparam logic [3:0] OFS_MODSTOP = 4'h2;
   localparam logic [3:0] OFS_STATUS = 4'h3;
   localparam logic [3:0] OFS_SETUP = 4'h4;
   // Control low: [3:0] channel enable per sub, [7:4] end irq enable
   localparam int unsigned CL_EN_POS = 0;
   localparam int unsigned CL_IE_POS = 4;
   // Control high: [1:0] full mode, [3:2] burst, [5:4] block, [7:6] dual
   localparam int unsigned CH_FAE_POS = 0;
   localparam int unsigned CH_BURST_POS = 2;
   localparam int unsigned CH_BLOCK_POS = 4;
   localparam int unsigned CH_DUAL_POS = 6;
   // Setup: [3:0] end pin enable, [5:4] single addr enable, [6] wbuf
   localparam int unsigned SU_TEE_POS = 0;
   localparam int unsigned SU_SAE_POS = 4;
   localparam int unsigned SU_WRITE_BUFFER_ENABLE_BIT_POS = 6;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic RST_MODSTOP = 1'b1;
   localparam int unsigned ADDR_LEAD_CYC = 1;
   localparam int unsigned SAMPLE_DELAY_CYC = 1;

   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_ADDR = 5'b00010,
      ST_READ = 5'b00100,
      ST_WRITE = 5'b01000,
      ST_HOLD = 5'b10000
   } dac_state_e;

   typedef struct packed
   {
      logic valid;
      logic [1:0] sub;
      logic internal;
   } dac_grant_s;

   typedef struct packed
   {
      logic req;
      logic ack;
      logic busy;
      logic ext_hold;
   } dac_bus_s;
endpackage

// ===== logic/dac_prio.sv
// Fixed-priority picker over the four sub-channels.
// Assumes request bits are already qualified by enables.
`timescale 1ns/1ps
module dac_prio
(
   input wire logic [3:0] req,
   output logic found,
   output logic [1:0] pick
);
   always_comb
   begin
      found = |req;
      pick = 2'd0;
      // Lowest index wins
      for (int i = dac_pkg::NSUB - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            pick = 2'(i);
         end
      end
   end
endmodule

// ===== logic/dac_irq.sv
// Level interrupt lines for end and break conditions.
// Assumes enables come straight from the control registers.
`timescale 1ns/1ps
module dac_irq
(
   input wire logic [3:0] chan_en,
   input wire logic [3:0] end_ie,
   input wire logic [1:0] full_mode,
   input wire logic [1:0] master_en,
   input wire logic [1:0] break_ie,
   output logic [3:0] irq
);
   // Per channel: A line is end, B line is end or break by mode
   genvar c;
   generate
      for (c = 0; c < 2; c++)
      begin : g_ch
         always_comb
         begin
            irq[2*c] = ~chan_en[2*c] & end_ie[2*c];
            if (full_mode[c])
            begin
               irq[2*c+1] = ~master_en[c] & break_ie[c];
            end
            else
            begin
               irq[2*c+1] = ~chan_en[2*c+1] & end_ie[2*c+1];
            end
         end
      end
   endgenerate
endmodule

// ===== logic/dac_arbiter.sv
// Channel arbitration, bus sharing and stop/resume control for the DMA block.
// Assumes a bus controller on ref_clk that grants and suspends the external bus.
`timescale 1ns/1ps
module dac_arbiter
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] xfer_req,
   input wire logic [3:0] xfer_internal,
   input wire logic nmi_req,
   input wire logic ext_bus_grant,
   input wire logic ext_contend,
   input wire logic unit_done,
   input wire logic block_done,
   input wire logic last_xfer,
   output logic ext_bus_req,
   output logic cpu_ext_hold,
   output logic addr_phase,
   output logic mar_update,
   output logic read_cycle,
   output logic write_cycle,
   output dac_pkg::dac_grant_s grant,
   output logic [3:0] req_sample_en,
   output logic [3:0] transfer_done_pin_en,
   output logic [1:0] transfer_ack_pin_en,
   output logic irq_ch0_primary,
   output logic irq_ch0_secondary,
   output logic irq_ch1_primary,
   output logic irq_ch1_secondary
);
   logic [7:0] ctrl_low_reg;
   logic [7:0] ctrl_high_reg;
   logic [7:0] setup_reg;
   logic [1:0] master_en_reg;
   logic [1:0] break_ie_reg;
   logic module_stop_reg;
   dac_pkg::dac_state_e state_reg;
   dac_pkg::dac_state_e state_next;
   dac_pkg::dac_grant_s grant_reg;
   logic [7:0] rdata_reg;
   logic [3:0] sample_hold_reg;
   logic [1:0] nmi_sync_reg;
   logic nmi_prev_reg;
   logic [3:0] eff_en;
   logic [3:0] qual_req;
   logic prio_found;
   logic [1:0] prio_pick;
   logic [1:0] full_mode;
   logic [1:0] burst_mode;
   logic [1:0] block_mode;
   logic [1:0] dual_mode;
   logic any_enabled;
   logic cur_ok;
   logic cur_sticky;
   logic nmi_edge;
   logic wbuf_en;
   logic acc_ok;
   logic wr_low;
   logic wr_high;
   logic wr_ms;
   logic wr_setup;
   logic [3:0] irq_vec;

   assign full_mode = ctrl_high_reg[dac_pkg::CH_FAE_POS +: 2];
   assign burst_mode = ctrl_high_reg[dac_pkg::CH_BURST_POS +: 2];
   assign block_mode = ctrl_high_reg[dac_pkg::CH_BLOCK_POS +: 2];
   assign dual_mode = ctrl_high_reg[dac_pkg::CH_DUAL_POS +: 2];
   assign wbuf_en = setup_reg[dac_pkg::SU_WRITE_BUFFER_ENABLE_BIT_POS];
   assign nmi_edge = nmi_sync_reg[1] & ~nmi_prev_reg;

   // Register access blocked while module stopped, except the module stop register
   assign acc_ok = ~module_stop_reg;
   assign wr_low = reg_wr & acc_ok & (reg_addr == dac_pkg::OFS_CTRL_LOW);
   assign wr_high = reg_wr & acc_ok & (reg_addr == dac_pkg::OFS_CTRL_HIGH);
   assign wr_setup = reg_wr & acc_ok & (reg_addr == dac_pkg::OFS_SETUP);
   assign wr_ms = reg_wr & (reg_addr == dac_pkg::OFS_MODSTOP);

   // Effective enables: full mode needs channel and master bits
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_en
         always_comb
         begin
            if (full_mode[g/2])
            begin
               eff_en[g] = (g % 2 == 0) && ctrl_low_reg[g] && master_en_reg[g/2];
            end
            else
            begin
               eff_en[g] = ctrl_low_reg[g];
            end
         end
      end
   endgenerate

   assign any_enabled = |ctrl_low_reg[3:0];
   assign qual_req = xfer_req & eff_en & sample_hold_reg;

   dac_prio u_prio
   (
      .req(qual_req),
      .found(prio_found),
      .pick(prio_pick)
   );

   // Still allowed to run the granted channel
   assign cur_ok = eff_en[grant_reg.sub];
   assign cur_sticky = burst_mode[grant_reg.sub[1]] | block_mode[grant_reg.sub[1]];

   // Interrupt event edge, synchronised from the pin
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         nmi_sync_reg <= 2'b00;
         nmi_prev_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         nmi_sync_reg <= {nmi_sync_reg[0], nmi_req};
         nmi_prev_reg <= nmi_sync_reg[1];
      end
   end

   // Control low register (channel enable, end irq enable)
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_low_reg <= dac_pkg::RST_CTRL;
      end
      else if (clk_en)
      begin
         if (wr_low)
         begin
            ctrl_low_reg <= reg_wdata;
         end
         else if (state_reg == dac_pkg::ST_HOLD && last_xfer && unit_done)
         begin
            ctrl_low_reg[grant_reg.sub] <= 1'b0;
         end
         for (int c = 0; c < 2; c++)
         begin
            if (nmi_edge && full_mode[c] && burst_mode[c])
            begin
               ctrl_low_reg[2*c+1] <= 1'b0;
            end
         end
      end
   end

   // Control high register (mode fields)
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_high_reg <= dac_pkg::RST_CTRL;
      end
      else if (clk_en && wr_high)
      begin
         ctrl_high_reg <= reg_wdata;
      end
   end

   // Setup register: end pin, ack pin, write buffer
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         setup_reg <= dac_pkg::RST_SETUP;
      end
      else if (clk_en && wr_setup)
      begin
         setup_reg <= reg_wdata;
      end
   end

   // Master enable and break irq enable; event clear wins over write
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         master_en_reg <= 2'b00;
         break_ie_reg <= 2'b00;
      end
      else if (clk_en)
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (nmi_edge && full_mode[c] && burst_mode[c])
            begin
               master_en_reg[c] <= 1'b0;
            end
            else if (wr_high)
            begin
               master_en_reg[c] <= reg_wdata[dac_pkg::CH_FAE_POS + c] ? master_en_reg[c] : 1'b0;
            end
            else if (wr_low && full_mode[c])
            begin
               master_en_reg[c] <= reg_wdata[2*c+1];
            end
         end
         if (wr_low)
         begin
            for (int c = 0; c < 2; c++)
            begin
               if (full_mode[c])
               begin
                  break_ie_reg[c] <= reg_wdata[dac_pkg::CL_IE_POS + 2*c + 1];
               end
            end
         end
      end
   end

   // Module stop: set refused while any channel is enabled
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         module_stop_reg <= dac_pkg::RST_MODSTOP;
      end
      else if (clk_en && wr_ms)
      begin
         if (!reg_wdata[0] || !any_enabled)
         begin
            module_stop_reg <= reg_wdata[0];
         end
      end
   end

   // Request sampling gate: one state after a buffered write starts
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sample_hold_reg <= 4'hF;
      end
      else if (clk_en && !module_stop_reg)
      begin
         if (state_reg == dac_pkg::ST_ADDR)
         begin
            sample_hold_reg[grant_reg.sub] <= 1'b0;
         end
         else if (state_reg == dac_pkg::ST_WRITE && wbuf_en)
         begin
            sample_hold_reg <= 4'hF;
         end
         else if (state_reg == dac_pkg::ST_IDLE)
         begin
            sample_hold_reg <= 4'hF;
         end
      end
   end

   // Transfer sequencing
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         dac_pkg::ST_IDLE:
         begin
            if (prio_found)
            begin
               state_next = dac_pkg::ST_ADDR;
            end
         end
         dac_pkg::ST_ADDR:
         begin
            // Internal targets run regardless of external contention
            if (grant_reg.internal || (ext_bus_grant && !ext_contend))
            begin
               state_next = dac_pkg::ST_READ;
            end
         end
         dac_pkg::ST_READ:
         begin
            if (unit_done)
            begin
               state_next = dac_pkg::ST_WRITE;
            end
         end
         dac_pkg::ST_WRITE:
         begin
            if (unit_done || wbuf_en)
            begin
               state_next = dac_pkg::ST_HOLD;
            end
         end
         dac_pkg::ST_HOLD:
         begin
            if (cur_sticky && cur_ok && !block_done && xfer_req[grant_reg.sub])
            begin
               state_next = dac_pkg::ST_ADDR;
            end
            else
            begin
               state_next = dac_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_next = dac_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= dac_pkg::ST_IDLE;
      end
      else if (clk_en && !module_stop_reg)
      begin
         state_reg <= state_next;
      end
   end

   // Grant latch; held through burst and block
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         grant_reg <= '0;
      end
      else if (clk_en && !module_stop_reg)
      begin
         if (state_reg == dac_pkg::ST_IDLE && prio_found)
         begin
            grant_reg.valid <= 1'b1;
            grant_reg.sub <= prio_pick;
            grant_reg.internal <= xfer_internal[prio_pick];
         end
         else if (state_next == dac_pkg::ST_IDLE)
         begin
            grant_reg.valid <= 1'b0;
         end
      end
   end

   // Read data one cycle after strobe
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_reg <= 8'h00;
      end
      else if (clk_en && reg_rd)
      begin
         if (!acc_ok && reg_addr != dac_pkg::OFS_MODSTOP)
         begin
            rdata_reg <= 8'h00;
         end
         else
         begin
            case (reg_addr)
               dac_pkg::OFS_CTRL_LOW: rdata_reg <= ctrl_low_reg;
               dac_pkg::OFS_CTRL_HIGH: rdata_reg <= ctrl_high_reg;
               dac_pkg::OFS_MODSTOP: rdata_reg <= {7'h00, module_stop_reg};
               dac_pkg::OFS_STATUS: rdata_reg <= {state_reg, grant_reg.sub, grant_reg.valid};
               dac_pkg::OFS_SETUP: rdata_reg <= setup_reg;
               default: rdata_reg <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_reg;

   // External bus request held over read and write as one unit
   assign ext_bus_req = grant_reg.valid && !grant_reg.internal
                        && state_reg != dac_pkg::ST_IDLE;
   // Lower masters wait until the DMA side lets go
   assign cpu_ext_hold = ext_bus_req;
   assign addr_phase = state_reg == dac_pkg::ST_ADDR;
   assign mar_update = addr_phase;
   // Contention pauses external reads in any mode, and external writes unless the channel is in dual mode
   assign read_cycle = state_reg == dac_pkg::ST_READ
                       && (grant_reg.internal || !ext_contend);
   assign write_cycle = state_reg == dac_pkg::ST_WRITE
                        && (grant_reg.internal || !ext_contend || dual_mode[grant_reg.sub[1]]);
   assign grant = grant_reg;
   assign req_sample_en = sample_hold_reg & eff_en;

   // Pin enables persist in module stop
   assign transfer_done_pin_en = setup_reg[dac_pkg::SU_TEE_POS +: 4];
   assign transfer_ack_pin_en = setup_reg[dac_pkg::SU_SAE_POS +: 2] & ~full_mode;

   dac_irq u_irq
   (
      .chan_en(ctrl_low_reg[3:0]),
      .end_ie(ctrl_low_reg[7:4]),
      .full_mode(full_mode),
      .master_en(master_en_reg),
      .break_ie(break_ie_reg),
      .irq(irq_vec)
   );

   // Level lines, not gated by module stop
   assign irq_ch0_primary = irq_vec[0];
   assign irq_ch0_secondary = irq_vec[1];
   assign irq_ch1_primary = irq_vec[2];
   assign irq_ch1_secondary = irq_vec[3];
endmodule

// ===== bench/dac_arbiter_asserts.sv
// Port checker for the DMA arbiter.
// Assumes a bind onto dac_arbiter, one ref_clk domain.
`timescale 1ns/1ps
module dac_arbiter_asserts
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic unit_done,
   input wire logic ext_contend,
   input wire logic ext_bus_req,
   input wire logic cpu_ext_hold,
   input wire logic addr_phase,
   input wire logic read_cycle,
   input wire logic write_cycle,
   input wire dac_pkg::dac_grant_s grant
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   hold_mirror_a: assert property (cpu_ext_hold == ext_bus_req)
      else $error("cpu hold differs from bus request");
   addr_lead_a: assert property (addr_phase && clk_en |=> addr_phase || read_cycle || ext_contend)
      else $error("no bus cycle after address");
   read_write_pair_a: assert property (read_cycle && unit_done && clk_en |=> write_cycle || ext_contend)
      else $error("read not followed by write");
   chan_lock_a: assert property (read_cycle || write_cycle |-> $stable(grant))
      else $error("grant moved mid transfer");
   phase_excl_a: assert property ($onehot0({addr_phase, read_cycle, write_cycle}))
      else $error("bus phases overlap");
   grant_live_a: assert property (addr_phase || read_cycle || write_cycle |-> grant.valid)
      else $error("cycle without grant");
   internal_free_a: assert property (
      (read_cycle || write_cycle) && grant.internal |-> !ext_bus_req)
      else $error("internal cycle asks for bus");
   gate_freeze_a: assert property (
      !clk_en |=> $stable(grant) && $stable(addr_phase)
      && (!$stable(ext_contend) || $stable({read_cycle, write_cycle})))
      else $error("state moved while gated");
   rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved without read");
   unit_pair_c: cover property (read_cycle && unit_done ##1 write_cycle);
   frozen_c: cover property (!clk_en && read_cycle);
   inner_grant_c: cover property ($rose(addr_phase) && grant.internal);
endmodule

// ===== bench/dac_bus_model.sv
// Bus controller model on the far side of the DMA arbiter.
// Assumes the bench drives contention and wait states.
`timescale 1ns/1ps
module dac_bus_model
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic ext_bus_req,
   input wire logic ext_contend,
   input wire logic read_cycle,
   input wire logic write_cycle,
   input wire logic internal,
   input wire logic [1:0] wait_cyc,
   output logic ext_bus_grant,
   output logic unit_done
);
   logic [1:0] cnt_reg;
   // Refresh or other masters take the bus first
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
         ext_bus_grant <= 1'b0;
      else
         ext_bus_grant <= ext_bus_req && !ext_contend;
   // Cycle ends after wait states; internal ones ignore the bus
   always_ff @(posedge ref_clk or negedge resetn)
      if (!resetn)
      begin
         cnt_reg <= 2'h0;
         unit_done <= 1'b0;
      end
      else if (unit_done)
      begin
         cnt_reg <= 2'h0;
         unit_done <= 1'b0;
      end
      else if ((read_cycle || write_cycle) && (internal || ext_bus_grant))
      begin
         if (cnt_reg >= wait_cyc)
            unit_done <= 1'b1;
         else
            cnt_reg <= cnt_reg + 2'h1;
      end
      else if (!(read_cycle || write_cycle))
         cnt_reg <= 2'h0;
endmodule

// ===== bench/tb_dac_arbiter.sv
// Self-checking bench for the DMA channel arbiter.
// Assumes dac_pkg, the arbiter, its checker and the bus model compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_dac_arbiter;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] xfer_req = 4'h0;
   logic [3:0] xfer_internal = 4'h0;
   logic nmi_req = 1'b0;
   logic ext_contend = 1'b0;
   logic block_done = 1'b0;
   logic last_xfer = 1'b0;
   logic [1:0] wait_cyc = 2'h0;
   logic rnd_on = 1'b0;
   logic drop_on = 1'b1;
   logic addr_q = 1'b0;
   logic in_rd = 1'b0;
   logic [7:0] v;
   logic [7:0] reg_rdata;
   logic ext_bus_grant, unit_done, ext_bus_req, cpu_ext_hold, addr_phase;
   logic mar_update, read_cycle, write_cycle;
   logic irq_ch0_primary, irq_ch0_secondary, irq_ch1_primary, irq_ch1_secondary;
   logic [3:0] req_sample_en, transfer_done_pin_en;
   logic [1:0] transfer_ack_pin_en;
   dac_pkg::dac_grant_s grant;
   wire [3:0] irqs = {irq_ch1_secondary, irq_ch1_primary, irq_ch0_secondary, irq_ch0_primary};
   int err_total = 0;
   int cmp_count = 0;
   int units = 0;
   int gidx;
   logic [1:0] got[$];
   logic [1:0] want[$] = '{2'h2, 2'h0, 2'h1, 2'h3};
   dac_arbiter DUT (.*);
   dac_bus_model u_bus (.ref_clk(ref_clk), .resetn(resetn), .ext_bus_req(ext_bus_req),
      .ext_contend(ext_contend), .read_cycle(read_cycle), .write_cycle(write_cycle),
      .internal(grant.internal), .wait_cyc(wait_cyc), .ext_bus_grant(ext_bus_grant),
      .unit_done(unit_done));
   initial
      forever #5 ref_clk = ~ref_clk;
   function automatic logic [3:0] exp_irq(input logic [7:0] c);
      return ~c[3:0] & c[7:4];
   endfunction
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask
   task automatic wait_idle();
      int q;
      q = 0;
      for (int i = 0; i < 400 && q < 8; i++)
      begin
         @(posedge ref_clk);
         q = (addr_phase || read_cycle || write_cycle) ? 0 : q + 1;
      end
      if (q < 8)
      begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic wait_units(input int n);
      for (int i = 0; i < 2000 && units < n; i++)
         @(posedge ref_clk);
      if (units < n)
      begin
         err_total++;
         stop_test();
      end
   endtask
   // Grant log and request retirement
   always @(posedge ref_clk)
   begin
      addr_q <= addr_phase;
      if (addr_phase && !addr_q)
         got.push_back(grant.sub);
      if (read_cycle)
         in_rd <= 1'b1;
      if ((read_cycle || in_rd) && unit_done && clk_en)
      begin
         units++;
         in_rd <= 1'b0;
         if (drop_on)
            xfer_req[grant.sub] <= 1'b0;
      end
   end
   always @(posedge ref_clk)
      if (rnd_on)
      begin
         ext_contend <= ($urandom % 4) == 0;
         clk_en <= ($urandom % 8) != 0;
         wait_cyc <= 2'($urandom);
      end
   initial
   begin
      #500000;
      err_total++;
      stop_test();
   end
   initial
   begin
      void'($urandom(24342));
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      rd_chk(4'h2, 8'h01);
      wr(4'h0, 8'h0F);
      wr(4'h2, 8'h00);
      rd_chk(4'h0, 8'h00);
      rd_chk(4'hE, 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         v = 8'($urandom);
         wr(4'h1, 8'($urandom) & 8'h03);
         wr(4'h0, v);
         #1;
         `CHK(irqs, exp_irq(v))
         rd_chk(4'h0, v);
      end
      wr(4'h0, 8'hF1);
      wr(4'h2, 8'h01);
      rd_chk(4'h2, 8'h00);
      wr(4'h1, 8'h01);
      wr(4'h0, 8'hF0);
      wr(4'h4, 8'h3F);
      wr(4'h2, 8'h01);
      rd_chk(4'h0, 8'h00);
      `CHK({irqs, transfer_done_pin_en, transfer_ack_pin_en}, 10'h3FE)
      wr(4'h2, 8'h00);
      wr(4'h4, 8'h40);
      wr(4'h1, 8'hC0);
      wr(4'h0, 8'h0F);
      got.delete();
      xfer_internal <= 4'($urandom);
      xfer_req <= 4'hC;
      rnd_on = 1'b1;
      for (int i = 0; i < 200 && got.size() == 0; i++)
         @(posedge ref_clk);
      xfer_req <= xfer_req | 4'h3;
      nmi_req <= 1'b1;
      wait_units(units + 4);
      rnd_on = 1'b0;
      @(posedge ref_clk);
      clk_en <= 1'b1;
      ext_contend <= 1'b0;
      nmi_req <= 1'b0;
      wait_idle();
      foreach (want[k])
         `CHK(got[k], want[k])
      rd_chk(4'h0, 8'h0F);
      drop_on = 1'b0;
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h05);
      wr(4'h0, 8'h37);
      gidx = got.size();
      xfer_req <= 4'h5;
      wait_units(units + 3);
      for (int k = gidx; k < got.size(); k++)
         `CHK(got[k], 2'h0)
      xfer_req <= 4'h1;
      nmi_req <= 1'b1;
      wait_idle();
      `CHK(irqs, exp_irq(8'h35))
      rd_chk(4'h0, 8'h35);
      wr(4'h0, 8'h37);
      wait_units(units + 2);
      `CHK(irqs, 4'h0)
      wr(4'h0, 8'h36);
      wait_idle();
      `CHK(irqs, exp_irq(8'h36))
      xfer_req <= 4'h0;
      stop_test();
   end
endmodule
bind dac_arbiter dac_arbiter_asserts u_chk (.*);
